/* opt_port_pkg.sv */
// constants, register map and carriers for the option-configured port logic
// assumes a 40 MHz bus clock; option choices are fixed at build time
package opt_port_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int HOLD_TIME_MS = 2000;
   localparam int HOLD_CYC = HOLD_TIME_MS * (CLK_HZ / 1000);
   localparam int NR_HZ = 4000;
   localparam int NR_CYC = CLK_HZ / NR_HZ;
   localparam int DIVIDED_CLOCK_OUT_MAX_HZ = 32768;
   localparam int DIVIDED_CLOCK_OUT_CHOICES = 8;
   localparam int OSC_XTAL_HZ = 32768;
   localparam int LCD_SEGS = 26;
   localparam int LCD_SEG_MAX_THIRD = 3 * LCD_SEGS;
   localparam int LCD_SEG_MAX_QUARTER = 4 * LCD_SEGS;

   localparam logic [7:0] ADDR_PORT_DATA = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_SPECIAL_OUTPUT_LATCH = 8'hf4;
   localparam logic [7:0] ADDR_PORT_DIRECTION_CONTROL = 8'hfc;

   localparam int LATCH_CLK_DC_BIT = 0;
   localparam int LATCH_MEL_DC_BIT = 2;
   localparam int DIR_BIT = 0;
   localparam logic [3:0] LATCH_RESET = 4'h0;
   localparam logic [3:0] DIR_RESET = 4'h0;
   localparam logic [3:0] PORT_RESET = 4'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   typedef enum logic [1:0] {
      MKR_NONE = 2'b00,
      MKR_TWO = 2'b01,
      MKR_THREE = 2'b10,
      MKR_FOUR = 2'b11
   } mkr_sel_e;

   typedef enum logic [1:0] {
      AUX_DC = 2'b00,
      AUX_MELODY_INV = 2'b01,
      AUX_ENVELOPE = 2'b10
   } aux_mode_e;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_DATA = 1'b1
   } bus_state_e;

   typedef struct packed {
      logic aux_key_in;
      logic key_in_3;
      logic key_in_2;
      logic key_in_1;
      logic key_in_0;
   } key_s;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } bidir_s;
endpackage

/* option_configured_port_logic.sv */
// option-configured key, special output, i/o port and lcd common logic
// assumes ahb-lite single word transfers, one slave, synchronous inputs
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module option_configured_port_logic
   import opt_port_pkg::*;
#(
   parameter mkr_sel_e MKR_SEL = MKR_TWO,
   parameter bit NR_KEYS = 1'b1,
   parameter bit NR_AUX = 1'b1,
   parameter bit CLK_OUT_MODE = 1'b0,
   parameter logic [2:0] DIVIDED_CLOCK_OUT_SEL = 3'h0,
   parameter aux_mode_e AUX_MODE = AUX_DC,
   parameter bit DUTY_THIRD = 1'b0,
   parameter bit OSC_CRYSTAL = 1'b1,
   parameter int HOLD_CYCLES = HOLD_CYC,
   parameter int NR_CYCLES = NR_CYC,
   parameter int DIVIDED_CLOCK_OUT_HALF = CLK_HZ / (2 * (DIVIDED_CLOCK_OUT_MAX_HZ >> DIVIDED_CLOCK_OUT_SEL))
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire key_s keys,
   input wire logic tone_output,
   input wire logic [3:0] bidir_in,
   output bidir_s bidir,
   output logic bidir_pulldown,
   output logic clock_or_dc_out,
   output logic melody_aux_out,
   output logic melody_aux_oe,
   output key_s keys_filtered,
   output logic system_reset,
   output logic [3:0] lcd_common_active,
   output logic crystal_clock
);
   bus_state_e state_q;
   logic [7:0] addr_q;
   logic write_q;
   logic [3:0] latch_q;
   logic [3:0] dir_q;
   logic [3:0] port_q;
   logic take;
   logic [31:0] nr_cnt_q;
   logic nr_tick;
   key_s samp_q;
   logic combo;
   logic [31:0] hold_cnt_q;
   logic [31:0] divided_clock_out_cnt_q;
   logic divided_clock_out_phase_q;
   logic [1:0] com_q;

   assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   // one wait state on every access so the pull-down settles before pins are sampled
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= BUS_IDLE;
         addr_q <= 8'h00;
         write_q <= 1'b0;
         hreadyout <= 1'b1;
      end
      else
      begin
         case (state_q)
            BUS_IDLE:
            begin
               if (take)
               begin
                  state_q <= BUS_DATA;
                  addr_q <= haddr[7:0];
                  write_q <= hwrite;
                  hreadyout <= 1'b0;
               end
            end
            BUS_DATA:
            begin
               state_q <= BUS_IDLE;
               hreadyout <= 1'b1;
            end
            default:
            begin
               state_q <= BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hresp <= 1'b0;
      end
      else
      begin
         hresp <= 1'b0;
      end
   end

   // register writes land in the wait cycle, when hwdata stands
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         latch_q <= LATCH_RESET;
         dir_q <= DIR_RESET;
         port_q <= PORT_RESET;
      end
      else if (state_q == BUS_DATA && write_q)
      begin
         case (addr_q)
            ADDR_SPECIAL_OUTPUT_LATCH: latch_q <= hwdata[3:0];
            ADDR_PORT_DIRECTION_CONTROL: dir_q <= hwdata[3:0];
            ADDR_PORT_DATA: port_q <= hwdata[3:0];
            default: port_q <= port_q;
         endcase
      end
   end

   // unmapped addresses read zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= RDATA_RESET;
      end
      else if (state_q == BUS_DATA && !write_q)
      begin
         case (addr_q)
            ADDR_SPECIAL_OUTPUT_LATCH: hrdata <= {28'h0, latch_q};
            ADDR_PORT_DIRECTION_CONTROL: hrdata <= {28'h0, dir_q};
            ADDR_PORT_DATA: hrdata <= {28'h0, dir_q[DIR_BIT] ? port_q : bidir_in};
            ADDR_STATUS: hrdata <= {26'h0, system_reset, keys_filtered};
            default: hrdata <= RDATA_RESET;
         endcase
      end
   end

   // pull-down only across the port read wait cycle, to keep leakage low
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bidir_pulldown <= 1'b0;
      end
      else
      begin
         bidir_pulldown <= take && !hwrite && haddr[7:0] == ADDR_PORT_DATA
            && state_q == BUS_IDLE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bidir <= '0;
      end
      else
      begin
         bidir.oe <= {4{dir_q[DIR_BIT]}};
         bidir.out <= port_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         nr_cnt_q <= 32'h0;
      end
      else if (nr_cnt_q == 32'(NR_CYCLES - 1))
      begin
         nr_cnt_q <= 32'h0;
      end
      else
      begin
         nr_cnt_q <= nr_cnt_q + 32'h1;
      end
   end

   assign nr_tick = (nr_cnt_q == 32'(NR_CYCLES - 1));

   // each key with its noise-reduction option on (NR_KEYS, NR_AUX) is sampled on the 4 kHz tick; slower response is the price of chatter immunity
   for (genvar i = 0; i < 5; i++)
   begin : g_nr
      localparam bit USE = (i == 4) ? NR_AUX : NR_KEYS;
      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            samp_q[i] <= 1'b0;
            keys_filtered[i] <= 1'b0;
         end
         else if (!USE)
         begin
            samp_q[i] <= keys[i];
            keys_filtered[i] <= keys[i];
         end
         else if (nr_tick)
         begin
            samp_q[i] <= keys[i];
            if (samp_q[i] == keys[i])
            begin
               keys_filtered[i] <= keys[i];
            end
         end
      end
   end

   always_comb
   begin
      case (MKR_SEL)
         MKR_TWO: combo = keys.key_in_0 && keys.key_in_1;
         MKR_THREE: combo = keys.key_in_0 && keys.key_in_1 && keys.key_in_2;
         MKR_FOUR: combo = keys.key_in_0 && keys.key_in_1 && keys.key_in_2 && keys.key_in_3;
         default: combo = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hold_cnt_q <= 32'h0;
         system_reset <= 1'b0;
      end
      else if (!combo)
      begin
         hold_cnt_q <= 32'h0;
         system_reset <= 1'b0;
      end
      else if (hold_cnt_q == 32'(HOLD_CYCLES - 1))
      begin
         system_reset <= 1'b1;
      end
      else
      begin
         hold_cnt_q <= hold_cnt_q + 32'h1;
      end
   end

   // the wave restarts from low at enable so no short first half appears
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         divided_clock_out_cnt_q <= 32'h0;
         divided_clock_out_phase_q <= 1'b0;
      end
      else if (!latch_q[LATCH_CLK_DC_BIT])
      begin
         divided_clock_out_cnt_q <= 32'h0;
         divided_clock_out_phase_q <= 1'b0;
      end
      else if (divided_clock_out_cnt_q == 32'(DIVIDED_CLOCK_OUT_HALF - 1))
      begin
         divided_clock_out_cnt_q <= 32'h0;
         divided_clock_out_phase_q <= !divided_clock_out_phase_q;
      end
      else
      begin
         divided_clock_out_cnt_q <= divided_clock_out_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clock_or_dc_out <= 1'b0;
      end
      else if (CLK_OUT_MODE)
      begin
         clock_or_dc_out <= latch_q[LATCH_CLK_DC_BIT] && divided_clock_out_phase_q;
      end
      else
      begin
         clock_or_dc_out <= latch_q[LATCH_CLK_DC_BIT];
      end
   end

   // envelope mode is open drain: pulls low while the tone is high
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         melody_aux_out <= 1'b0;
         melody_aux_oe <= 1'b1;
      end
      else
      begin
         case (AUX_MODE)
            AUX_MELODY_INV:
            begin
               melody_aux_out <= !tone_output;
               melody_aux_oe <= 1'b1;
            end
            AUX_ENVELOPE:
            begin
               melody_aux_out <= 1'b0;
               melody_aux_oe <= tone_output;
            end
            default:
            begin
               melody_aux_out <= latch_q[LATCH_MEL_DC_BIT];
               melody_aux_oe <= 1'b1;
            end
         endcase
      end
   end

   // common scan steps on the sampling tick; frame rate is not modelled further
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         com_q <= 2'h0;
         lcd_common_active <= 4'h0;
         crystal_clock <= 1'b0;
      end
      else
      begin
         crystal_clock <= OSC_CRYSTAL;
         if (nr_tick)
         begin
            if (DUTY_THIRD && com_q == 2'h2)
            begin
               com_q <= 2'h0;
            end
            else
            begin
               com_q <= com_q + 2'h1;
            end
         end
         lcd_common_active <= 4'h1 << com_q;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_port_read;
      take && !hwrite && haddr[7:0] == ADDR_PORT_DATA && state_q == BUS_IDLE;
   endsequence

   sequence s_combo_held;
      combo [*8];
   endsequence

   // keys held and the hold counter at its end point
   sequence s_hold_done;
      s_combo_held ##0 hold_cnt_q == 32'(HOLD_CYCLES - 1);
   endsequence

   a_mkr_never_off: assert property (MKR_SEL == MKR_NONE |-> !system_reset)
      else $error("key reset fired while option off");
   a_mkr_needs_combo: assert property (!combo |=> !system_reset)
      else $error("key reset without key combination");
   a_mkr_hold_count: assert property ($rose(system_reset) |-> hold_cnt_q == 32'(HOLD_CYCLES - 1))
      else $error("key reset before hold time");
   a_dc_out_follows: assert property (!CLK_OUT_MODE ##1 1 |-> clock_or_dc_out == $past(latch_q[0]))
      else $error("dc output not following latch");
   a_divided_clock_out_stops_low: assert property (CLK_OUT_MODE && !latch_q[0] |=> !clock_or_dc_out)
      else $error("clock output not low when disabled");
   a_divided_clock_out_half_toggle: assert property (latch_q[0] && divided_clock_out_cnt_q == 32'(DIVIDED_CLOCK_OUT_HALF - 1)
      ##1 latch_q[0] |-> divided_clock_out_phase_q != $past(divided_clock_out_phase_q))
      else $error("square wave did not toggle at half period");
   a_melody_inverse: assert property (AUX_MODE == AUX_MELODY_INV |=> melody_aux_out == !$past(tone_output))
      else $error("inverse output not complement of tone");
   a_dir_sets_oe: assert property (1 |=> bidir.oe == {4{$past(dir_q[0])}})
      else $error("port direction mismatch");
   a_pull_on_read: assert property (s_port_read |=> bidir_pulldown ##1 !bidir_pulldown)
      else $error("pull-down not confined to read");
   a_filter_two_samples: assert property (NR_KEYS && $changed(keys_filtered[0])
      |-> $past(samp_q[0]) == keys_filtered[0])
      else $error("filtered key changed on one sample");
   a_com_last_off: assert property (DUTY_THIRD ##1 1 |-> !lcd_common_active[3])
      else $error("fourth common driven in third duty");
   a_combo_then_reset: assert property (s_hold_done |=> system_reset)
      else $error("held keys did not reset");
endmodule
`default_nettype wire

/* port_far_side.sv */
// far-side model: tone source and the four port pins
// assumes keys come straight from the bench and one bus clock
`timescale 1ns/100ps
`default_nettype none
module port_far_side
   import opt_port_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire bidir_s bidir,
   input wire logic bidir_pulldown,
   input wire logic drive_en,
   input wire logic [3:0] drive_val,
   output logic tone_output,
   output logic [3:0] bidir_in
);
   logic [3:0] float_q;
   logic [2:0] tone_cnt_q;
   logic [3:0] ext_w;
   // uneven tone spacing so a fixed lag cannot pass by luck
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tone_cnt_q <= 3'h0;
         tone_output <= 1'b0;
      end
      else
      begin
         tone_cnt_q <= tone_cnt_q + 3'h1;
         if (tone_cnt_q == 3'h2 || tone_cnt_q == 3'h7)
            tone_output <= ~tone_output;
      end
   end
   // an undriven pin keeps changing, never holds its last level
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         float_q <= 4'h5;
      else
         float_q <= ~bidir_in;
   end
   assign ext_w = drive_en ? drive_val : (bidir_pulldown ? 4'h0 : float_q);
   assign bidir_in = (bidir.out & bidir.oe) | (ext_w & ~bidir.oe);
endmodule
`default_nettype wire

/* test_option_configured_port_logic.sv */
// bench for the option-configured port logic: bus reads queued, pins checked
// assumes short counts: hold 20, filter tick 4, clock half period 3
`timescale 1ns/100ps
`default_nettype none
module test_option_configured_port_logic;
   import opt_port_pkg::*;
   localparam int HOLD = 20;
   localparam int HALF = 3;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mon_rd;
   logic [31:0] haddr, hwdata, hrdata, r, d;
   logic [1:0] htrans;
   logic [2:0] hsize;
   key_s keys, keys_filtered;
   bidir_s bidir;
   logic bidir_pulldown, clock_or_dc_out, melody_aux_out, melody_aux_oe;
   logic system_reset, crystal_clock, tone_output, drive_en, t;
   logic [3:0] lcd_common_active, bidir_in, drive_val, seen;
   // second build: dc outputs, key reset off, third duty, rc oscillator
   logic alt_dc_out, alt_aux_out, alt_reset, alt_xtal;
   logic [3:0] alt_com, alt_seen;
   int fail_count, comparisons, pd_seen, n;
   logic [31:0] exp_q[$];

   option_configured_port_logic #(.CLK_OUT_MODE(1'b1), .AUX_MODE(AUX_MELODY_INV),
      .HOLD_CYCLES(HOLD), .NR_CYCLES(4), .DIVIDED_CLOCK_OUT_HALF(HALF)) u_option_configured_port_logic (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .keys(keys),
      .tone_output(tone_output), .bidir_in(bidir_in), .bidir(bidir),
      .bidir_pulldown(bidir_pulldown), .clock_or_dc_out(clock_or_dc_out),
      .melody_aux_out(melody_aux_out), .melody_aux_oe(melody_aux_oe),
      .keys_filtered(keys_filtered), .system_reset(system_reset),
      .lcd_common_active(lcd_common_active), .crystal_clock(crystal_clock));
   option_configured_port_logic #(.MKR_SEL(MKR_NONE), .DUTY_THIRD(1'b1), .OSC_CRYSTAL(1'b0),
      .HOLD_CYCLES(HOLD), .NR_CYCLES(4)) u_option_configured_port_logic_alt (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(), .hresp(), .hrdata(), .keys(keys),
      .tone_output(tone_output), .bidir_in(bidir_in), .bidir(),
      .bidir_pulldown(), .clock_or_dc_out(alt_dc_out),
      .melody_aux_out(alt_aux_out), .melody_aux_oe(),
      .keys_filtered(), .system_reset(alt_reset),
      .lcd_common_active(alt_com), .crystal_clock(alt_xtal));
   port_far_side u_port_far_side (.hclk(hclk), .hresetn(hresetn), .bidir(bidir),
      .bidir_pulldown(bidir_pulldown), .drive_en(drive_en), .drive_val(drive_val),
      .tone_output(tone_output), .bidir_in(bidir_in));

   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      comparisons++;
      if (seen_v !== exp_v)
      begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
      end
   endtask

   task automatic conclude;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // single word transfer; for a read, dv is the expected word
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dv);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= HTRANS_NONSEQ;
      @(posedge hclk);
      while (!hreadyout)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= dv;
      mon_rd <= !wr;
      if (!wr)
         exp_q.push_back(dv);
      @(posedge hclk);
      while (!hreadyout)
         @(posedge hclk);
      mon_rd <= 1'b0;
   endtask

   always @(posedge hclk)
   begin
      if (mon_rd && hreadyout)
         check(hrdata, exp_q.pop_front());
      if (bidir_pulldown)
      begin
         pd_seen++;
         check(mon_rd && !hwrite && haddr[7:0] == ADDR_PORT_DATA, 1'b1);
      end
   end

   initial
   begin
      #(25 * 4000);
      fail_count++;
      conclude();
   end

   initial
   begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata, keys, drive_en, drive_val} = '0;
      {mon_rd, hresetn, fail_count, comparisons, pd_seen, seen, alt_seen} = '0;
      void'($urandom(53232));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, ADDR_SPECIAL_OUTPUT_LATCH, {28'h0, LATCH_RESET});
      bus(0, ADDR_PORT_DIRECTION_CONTROL, {28'h0, DIR_RESET});
      bus(0, 8'h80, 32'h0);
      check(crystal_clock, 1'b1);
      check(alt_xtal, 1'b0);
      check(alt_aux_out, 1'b0);
      check(hresp, 1'b0);
      r = $urandom | 32'h1;
      bus(1, ADDR_SPECIAL_OUTPUT_LATCH, r);
      bus(0, ADDR_SPECIAL_OUTPUT_LATCH, r & 32'hf);
      check(alt_dc_out, 1'b1);
      check(alt_aux_out, r[2]);
      n = 0;
      @(negedge hclk);
      while (clock_or_dc_out !== 1'b1 && n < 20)
      begin
         @(negedge hclk);
         n++;
      end
      for (int i = 0; i < 4 * HALF; i++)
      begin
         check(clock_or_dc_out, ((i / HALF) % 2) == 0);
         @(negedge hclk);
      end
      @(posedge hclk);
      bus(1, ADDR_SPECIAL_OUTPUT_LATCH, r & 32'he);
      repeat (8)
      begin
         @(negedge hclk);
         check(clock_or_dc_out, 1'b0);
      end
      check(alt_dc_out, 1'b0);
      check(alt_aux_out, r[2]);
      // output lags its input by one register stage
      repeat (16)
      begin
         t = tone_output;
         @(negedge hclk);
         check(melody_aux_out, !t);
      end
      check(melody_aux_oe, 1'b1);
      @(posedge hclk);
      d = $urandom & 32'hf;
      bus(1, ADDR_PORT_DIRECTION_CONTROL, 32'h1);
      bus(1, ADDR_PORT_DATA, d);
      @(negedge hclk);
      check(bidir, {d[3:0], 4'hf});
      @(posedge hclk);
      bus(0, ADDR_PORT_DATA, d);
      bus(1, ADDR_PORT_DIRECTION_CONTROL, 32'hfffffffe);
      @(negedge hclk);
      check(bidir.oe, 4'h0);
      @(posedge hclk);
      drive_en <= 1'b1;
      drive_val <= ~d[3:0];
      bus(0, ADDR_PORT_DATA, ~d & 32'hf);
      drive_en <= 1'b0;
      bus(0, ADDR_PORT_DATA, 32'h0);
      keys <= {1'b0, r[3:2], 2'b01};
      repeat (HOLD + 6) @(negedge hclk);
      check(system_reset, 1'b0);
      @(posedge hclk);
      keys <= {1'b0, r[3:2], 2'b11};
      repeat (HOLD - 4) @(negedge hclk);
      check(system_reset, 1'b0);
      repeat (8) @(negedge hclk);
      check(system_reset, 1'b1);
      check(alt_reset, 1'b0);
      @(posedge hclk);
      keys <= 5'h00;
      repeat (2) @(negedge hclk);
      check(system_reset, 1'b0);
      // the filter needs two agreeing ticks before the released keys read low
      repeat (12) @(negedge hclk);
      check(keys_filtered, 5'h00);
      @(posedge hclk);
      keys <= 5'h10;
      @(posedge hclk);
      keys <= 5'h00;
      repeat (12)
      begin
         @(negedge hclk);
         check(keys_filtered, 5'h00);
      end
      @(posedge hclk);
      keys <= 5'h10;
      repeat (2) @(negedge hclk);
      check(keys_filtered, 5'h00);
      repeat (12) @(negedge hclk);
      check(keys_filtered, 5'h10);
      @(posedge hclk);
      bus(0, ADDR_STATUS, 32'h10);
      n = 0;
      repeat (40)
      begin
         @(negedge hclk);
         seen = seen | lcd_common_active;
         alt_seen = alt_seen | alt_com;
         n = n + ($countones(lcd_common_active) != 1);
      end
      check(seen, 4'hf);
      check(alt_seen, 4'h7);
      check(n, 0);
      check(pd_seen, 3);
      check(exp_q.size(), 0);
      conclude();
   end
endmodule
`default_nettype wire
